// ==== hw/acc_pkg.sv ====
package acc_pkg;

   // Clock rate of pclk
   localparam int unsigned PCLK_MHZ = 250;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL0   = 8'h00;  // converter_control_zero
   localparam logic [7:0] OFF_CTRL1   = 8'h04;  // converter_control_one
   localparam logic [7:0] OFF_CTRL2   = 8'h08;  // converter_control_two
   localparam logic [7:0] OFF_RES_HI  = 8'h0c;  // conversion_result_high
   localparam logic [7:0] OFF_RES_LO  = 8'h10;  // conversion_result_low
   localparam logic [7:0] OFF_FLAGS   = 8'h14;  // peripheral_interrupt_flags_one
   localparam logic [7:0] OFF_ENABLES = 8'h18;  // peripheral_interrupt_enables_one
   localparam logic [7:0] OFF_PRIO    = 8'h1c;  // peripheral_interrupt_priority_one
   localparam logic [7:0] OFF_PORT    = 8'h20;  // Port read view of the channel pins

   // Field positions
   localparam int CTRL0_EN      = 0;  // converter_enable
   localparam int CTRL0_GO      = 1;  // Conversion run flag
   localparam int CTRL0_CHS     = 2;  // channel_select, 4 bits
   localparam int CTRL1_PCFG    = 0;  // port_analog_config, 4 bits
   localparam int CTRL1_VCFG    = 4;  // Reference select, 2 bits
   localparam int CTRL2_ADCS    = 0;  // conversion_clock_select, 3 bits
   localparam int CTRL2_ACQT    = 3;  // acquisition_time_select, 3 bits
   localparam int CTRL2_ADFM    = 7;  // Result right justify
   localparam int FLAGS_DONE    = 6;  // conversion_done_flag

   // Reset values
   localparam logic [3:0] PCFG_RST_ANALOG  = 4'h0;
   localparam logic [3:0] PCFG_RST_DIGITAL = 4'h7;
   localparam logic [2:0] ACQT_RST         = 3'h0;

   // Sequencing constants
   localparam logic [4:0] WAIT_TAD     = 5'h02;  // Gap after complete or abort
   localparam logic [4:0] CONV_TAD     = 5'h0b;  // Bit periods per conversion
   localparam int unsigned INSTR_NS    = 16;     // One instruction cycle, ns
   localparam logic [2:0] INSTR_CYC    = 3'((INSTR_NS * PCLK_MHZ + 999) / 1000);
   localparam logic [3:0] TRIG_MODE    = 4'hb;   // Compare mode with event trigger
   localparam int         NUM_CH       = 13;     // Channel pins

   // Sequencer states
   typedef enum logic [2:0] {
      ST_OFF   = 3'b000,
      ST_WAIT  = 3'b001,
      ST_TRACK = 3'b010,
      ST_ACQ   = 3'b011,
      ST_DELAY = 3'b100,
      ST_CONV  = 3'b101
   } acc_state_t;

   // Controls toward the analog front end
   typedef struct packed {
      logic       sample_en;
      logic       discharge;
      logic       convert;
      logic [3:0] channel;
      logic [9:0] dac_code;
   } acc_ana_t;

endpackage : acc_pkg

// ==== hw/acc_tad_gen.sv ====
`timescale 1ns/100ps
module acc_tad_gen (
   // Clock and reset
   input  wire  logic       pclk,
   input  wire  logic       presetn,
   // Control
   input  wire  logic [2:0] clk_sel,
   input  wire  logic       restart,
   // Internal RC source pin
   input  wire  logic       rc_clk,
   // Bit period tick
   output logic             tad_tick
);
   import acc_pkg::*;

   logic       rc_s1;   // First stage, read only by rc_s2
   logic       rc_s2;   // Synchronised RC level
   logic       rc_s3;   // Previous level for edge detect
   logic [5:0] div_cnt; // Oscillator period counter

   // Exponent of the divide ratio from the select code
   function automatic logic [2:0] div_exp(input logic [2:0] sel);
      div_exp = 3'(1 + sel[2] + 2 * sel[1:0]);
   endfunction : div_exp

   // RC source crossing, two flops then edge register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_s1 <= 1'b0;
         rc_s2 <= 1'b0;
         rc_s3 <= 1'b0;
      end else begin
         rc_s1 <= rc_clk;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end

   // Divider; restart realigns so the first period is whole
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b0;
      end else if (clk_sel[1:0] == 2'b11) begin
         // RC source: one tick per rising edge
         div_cnt  <= 6'h00;
         tad_tick <= rc_s2 & ~rc_s3;
      end else if (restart) begin
         // The state change edge is already the first cycle of the period;
         // starting at zero would stretch every first period by one pclk
         div_cnt  <= 6'h01;
         tad_tick <= 1'b0;
      end else if (div_cnt == 6'((7'h01 << div_exp(clk_sel)) - 7'h01)) begin
         div_cnt  <= 6'h00;
         tad_tick <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + 6'h01;
         tad_tick <= 1'b0;
      end
   end

endmodule : acc_tad_gen

// ==== hw/acc_conv_ctrl.sv ====
// What this block does
// - Sequence ignores channel and direction settings
// - Port read gives zero on analog pins
// - Digital-configured pins still convert when selected
// - Strap picks analog or digital config reset
// - Manual acquisition starts conversion one instruction later
// - Code 010 acquires four bit periods first
// - Clearing run flag aborts conversion at once
// - Abort leaves result pair untouched
// - Two bit periods wait, then acquisition resumes
// - Sampling array discharged before every sample
// - Compare trigger sets run flag when enabled
// - Every trigger clears the timer counter
// - Disabled converter ignores trigger, timer still clears
// - Completion clears run, sets done, resamples
// - Acquisition select gives 2 to 20 periods
// - Conversion lasts eleven bit periods
// - Clock select picks divide ratio or RC
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module acc_conv_ctrl (
   // Clock and reset
   input  wire  logic             pclk,
   input  wire  logic             presetn,
   // APB slave
   input  wire  logic             psel,
   input  wire  logic             penable,
   input  wire  logic             pwrite,
   input  wire  logic [7:0]       paddr,
   input  wire  logic [31:0]      pwdata,
   output logic       [31:0]      prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Pins and straps
   input  wire  logic [12:0]      port_pin,
   input  wire  logic             rc_clk,
   input  wire  logic             portb_analog_default,
   // Compare unit two
   input  wire  logic [3:0]       compare_mode_field,
   input  wire  logic             special_event,
   output logic                   timer_clear,
   // Analog front end
   input  wire  logic             cmp_result,
   output acc_pkg::acc_ana_t      ana
);
   import acc_pkg::*;

   // Register state
   logic        enable;        // converter_enable
   logic        go;            // Conversion run flag
   logic [3:0]  chs;           // channel_select
   logic [3:0]  pcfg;          // port_analog_config
   logic [1:0]  vcfg;          // Reference select, storage only
   logic        adfm;          // Right justify result
   logic [2:0]  acqt;          // acquisition_time_select
   logic [2:0]  adcs;          // conversion_clock_select
   logic [7:0]  res_hi;        // Result high byte
   logic [7:0]  res_lo;        // Result low byte
   logic        done_flag;     // conversion_done_flag
   logic [7:0]  ie_reg;        // Enables, storage only
   logic [7:0]  ip_reg;        // Priorities, storage only

   // Sequencer state
   acc_state_t  state;
   acc_state_t  next_state;
   logic [4:0]  tad_cnt;       // Bit periods spent in the state
   logic [2:0]  dly_cnt;       // pclk cycles in the instruction delay
   logic [9:0]  sar;           // Trial code
   logic [9:0]  mask;          // Bit under trial
   logic        tad_tick;      // One pulse per bit period
   logic        complete;      // Last bit decided this cycle
   logic        abort;         // Run flag dropped mid sequence
   logic        trig_go;       // Trigger accepted

   // Synchronisers and strap capture
   logic [12:0] pin_s1;        // First stage, read only by pin_s2
   logic [12:0] pin_s2;
   logic        strap_s1;      // First stage, read only by strap_s2
   logic        strap_s2;
   logic [1:0]  init_cnt;      // Cycles since reset release

   // Bus decode
   logic        wr_en;
   logic        rd_setup;
   logic [31:0] rd_mux;
   logic        rd_hit;
   logic [9:0]  final_code;

   // Channels treated as analog for a given config code
   function automatic logic [12:0] analog_mask(input logic [3:0] cfg);
      analog_mask = 13'h0000;
      for (int i = 0; i < NUM_CH; i++) begin
         analog_mask[i] = (i + int'(cfg)) < 15;
      end
   endfunction : analog_mask

   // Automatic acquisition length in bit periods, zero is manual
   function automatic logic [4:0] acq_len(input logic [2:0] code);
      case (code)
         3'h0:    acq_len = 5'h00;
         3'h1:    acq_len = 5'h02;
         3'h2:    acq_len = 5'h04;
         3'h3:    acq_len = 5'h06;
         3'h4:    acq_len = 5'h08;
         3'h5:    acq_len = 5'h0c;
         3'h6:    acq_len = 5'h10;
         default: acq_len = 5'h14;
      endcase
   endfunction : acq_len

   // Bit period source; divider realigned on each sequencer step, RC edges are not
   acc_tad_gen u_tad (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_sel  (adcs),
      .restart  (next_state != state),
      .rc_clk   (rc_clk),
      .tad_tick (tad_tick)
   );

   assign wr_en      = psel & penable & pready & pwrite;
   assign rd_setup   = psel & ~penable;
   assign trig_go    = special_event & enable & (compare_mode_field == TRIG_MODE);
   assign abort      = !go && (state == ST_ACQ || state == ST_DELAY || state == ST_CONV);
   assign complete   = go && state == ST_CONV && tad_tick && tad_cnt == CONV_TAD - 5'h01;
   assign final_code = cmp_result ? sar : (sar & ~mask);

   // Pin and strap synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1   <= 13'h0000;
         pin_s2   <= 13'h0000;
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         pin_s1   <= port_pin;
         pin_s2   <= pin_s1;
         strap_s1 <= portb_analog_default;
         strap_s2 <= strap_s1;
      end
   end

   // Next state; channel and pin direction play no part here
   always_comb begin
      next_state = state;
      case (state)
         ST_OFF:   if (enable) next_state = ST_WAIT;
         ST_WAIT:  if (tad_tick && tad_cnt == WAIT_TAD - 5'h01) next_state = ST_TRACK;
         ST_TRACK: begin
            if (go && acqt == ACQT_RST) next_state = ST_DELAY;
            else if (go) next_state = ST_ACQ;
         end
         ST_ACQ:   if (tad_tick && tad_cnt == acq_len(acqt) - 5'h01) next_state = ST_CONV;
         ST_DELAY: if (dly_cnt == INSTR_CYC - 3'h1) next_state = ST_CONV;
         ST_CONV:  if (complete) next_state = ST_WAIT;
         default:  next_state = ST_OFF;
      endcase
      // Abort goes straight to the wait gap
      if (abort) next_state = ST_WAIT;
      // Disable overrides everything
      if (!enable) next_state = ST_OFF;
   end

   // State and counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= ST_OFF;
         tad_cnt <= 5'h00;
         dly_cnt <= 3'h0;
      end else begin
         state   <= next_state;
         tad_cnt <= (next_state != state) ? 5'h00 : tad_cnt + 5'(tad_tick);
         dly_cnt <= (next_state != state) ? 3'h0 : dly_cnt + 3'h1;
      end
   end

   // Successive approximation, first period sets up the top trial
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sar  <= 10'h000;
         mask <= 10'h000;
      end else if (state == ST_CONV && tad_tick) begin
         if (tad_cnt == 5'h00) begin
            sar  <= 10'h200;
            mask <= 10'h200;
         end else begin
            sar  <= final_code | (mask >> 1);
            mask <= mask >> 1;
         end
      end else if (state != ST_CONV) begin
         sar  <= 10'h000;
         mask <= 10'h000;
      end
   end

   // Front end strobes track the state register exactly; channel and trial code follow chs and sar a cycle late
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ana <= '0;
      end else begin
         ana.sample_en <= next_state == ST_TRACK || next_state == ST_ACQ;
         ana.discharge <= next_state == ST_WAIT;
         ana.convert   <= next_state == ST_CONV;
         ana.channel   <= chs;
         ana.dac_code  <= sar;
      end
   end

   // Timer clear on every trigger, enabled or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) timer_clear <= 1'b0;
      else          timer_clear <= special_event;
   end

   // Run flag: trigger set beats every clear, software set beats done
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go     <= 1'b0;
         enable <= 1'b0;
         chs    <= 4'h0;
      end else begin
         if (trig_go) go <= 1'b1;
         else if (wr_en && paddr == OFF_CTRL0) go <= pwdata[CTRL0_GO];
         else if (complete || !enable) go <= 1'b0;
         if (wr_en && paddr == OFF_CTRL0) begin
            enable <= pwdata[CTRL0_EN];
            chs    <= pwdata[CTRL0_CHS +: 4];
         end
      end
   end

   // Config registers; port config loads from the strap once it settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcfg     <= PCFG_RST_ANALOG;
         vcfg     <= 2'h0;
         adfm     <= 1'b0;
         acqt     <= ACQT_RST;
         adcs     <= 3'h0;
         ie_reg   <= 8'h00;
         ip_reg   <= 8'h00;
         init_cnt <= 2'h0;
      end else begin
         if (init_cnt != 2'h3) begin
            init_cnt <= init_cnt + 2'h1;
            pcfg     <= strap_s2 ? PCFG_RST_ANALOG : PCFG_RST_DIGITAL;
         end else if (wr_en && paddr == OFF_CTRL1) begin
            pcfg <= pwdata[CTRL1_PCFG +: 4];
            vcfg <= pwdata[CTRL1_VCFG +: 2];
         end
         if (wr_en && paddr == OFF_CTRL2) begin
            adfm <= pwdata[CTRL2_ADFM];
            acqt <= pwdata[CTRL2_ACQT +: 3];
            adcs <= pwdata[CTRL2_ADCS +: 3];
         end
         if (wr_en && paddr == OFF_ENABLES) ie_reg <= pwdata[7:0];
         if (wr_en && paddr == OFF_PRIO)    ip_reg <= pwdata[7:0];
      end
   end

   // Result pair: only completion or software writes change it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_hi <= 8'h00;
         res_lo <= 8'h00;
      end else if (complete) begin
         res_hi <= adfm ? {6'h00, final_code[9:8]} : final_code[9:2];
         res_lo <= adfm ? final_code[7:0] : {final_code[1:0], 6'h00};
      end else begin
         if (wr_en && paddr == OFF_RES_HI) res_hi <= pwdata[7:0];
         if (wr_en && paddr == OFF_RES_LO) res_lo <= pwdata[7:0];
      end
   end

   // Done flag: hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) done_flag <= 1'b0;
      else if (complete) done_flag <= 1'b1;
      else if (wr_en && paddr == OFF_FLAGS) done_flag <= pwdata[FLAGS_DONE];
   end

   // Read mux; unmapped addresses answer zero with an error
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == OFF_CTRL0) rd_mux = {26'h0, chs, go, enable};
      else if (paddr == OFF_CTRL1) rd_mux = {26'h0, vcfg, pcfg};
      else if (paddr == OFF_CTRL2) rd_mux = {24'h0, adfm, 1'b0, acqt, adcs};
      else if (paddr == OFF_RES_HI) rd_mux = {24'h0, res_hi};
      else if (paddr == OFF_RES_LO) rd_mux = {24'h0, res_lo};
      else if (paddr == OFF_FLAGS) rd_mux = {25'h0, done_flag, 6'h00};
      else if (paddr == OFF_ENABLES) rd_mux = {24'h0, ie_reg};
      else if (paddr == OFF_PRIO) rd_mux = {24'h0, ip_reg};
      else if (paddr == OFF_PORT) rd_mux = {19'h0, pin_s2 & ~analog_mask(pcfg)};
      else rd_hit = 1'b0;
   end

   // APB answer: one wait-free access phase per transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_setup;
         pslverr <= rd_setup & ~rd_hit;
         if (rd_setup && !pwrite) prdata <= rd_mux;
      end
   end

   // Checks
   done_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      complete && !trig_go |=> done_flag && !go && state == ST_WAIT)
      else $error("completion did not set done and clear run");
   keep_res_a: assert property (@(posedge pclk) disable iff (!presetn)
      abort && !(wr_en && (paddr == OFF_RES_HI || paddr == OFF_RES_LO))
      |=> $stable(res_hi) && $stable(res_lo))
      else $error("abort changed the result pair");
   abort_now_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_CONV && !go && enable |=> state == ST_WAIT)
      else $error("cleared run flag did not abort");
   wait_two_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state == ST_WAIT) && enable |-> state == ST_WAIT [*2] ##0 tad_cnt < WAIT_TAD)
      else $error("wait gap too short");
   disch_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_TRACK && $past(state) != ST_TRACK |-> $past(ana.discharge))
      else $error("sample without discharge");
   trig_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      trig_go |=> go)
      else $error("trigger did not set run flag");
   timer_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      special_event |=> timer_clear)
      else $error("trigger did not clear timer");
   ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
      special_event && !enable && !wr_en |=> !go || $past(go))
      else $error("disabled converter took trigger");
   manual_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_TRACK && go && enable && acqt == ACQT_RST
      |=> state == ST_DELAY [*4] ##1 (state == ST_CONV || !go || !enable))
      else $error("manual start not one instruction late");
   acq_four_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == ST_ACQ && tad_tick && tad_cnt == 5'h03 && acqt == 3'h2 && go && enable
      |=> state == ST_CONV)
      else $error("acquisition of four periods not honoured");
   conv_len_a: assert property (@(posedge pclk) disable iff (!presetn)
      complete |-> mask == 10'h001 && state == ST_CONV)
      else $error("conversion length wrong");

endmodule : acc_conv_ctrl

// ==== dv/acc_far_model.sv ====
`timescale 1ns/100ps
module acc_far_model (
   // Clock
   input  wire  logic            pclk,
   // Analog level and trigger request
   input  wire  logic [9:0]      level,
   input  wire  logic            fire,
   // Front end controls from the block
   input  wire  acc_pkg::acc_ana_t ana,
   // Comparator and compare unit outputs
   output logic                  cmp_result,
   output logic                  special_event
);
   import acc_pkg::*;
   logic toggle = 1'b0;  // Junk pattern when no trial is on

   // Junk source for the released comparator
   always_ff @(posedge pclk) begin
      toggle <= ~toggle;
   end

   // Comparator follows the trial code at once, as the analog part does;
   // half-step offset keeps the trial never equal to the input
   always_comb begin
      // Released comparator output wanders so stale bits cannot pass
      if (ana.convert) begin
         cmp_result = ({level, 1'b1} > {ana.dac_code, 1'b0});
      end else begin
         cmp_result = toggle;
      end
   end

   // One-cycle trigger pulse per request
   always_ff @(posedge pclk) begin
      special_event <= fire;
   end
endmodule : acc_far_model

// ==== dv/test_adc_conversion_control.sv ====
`timescale 1ns/100ps
module test_adc_conversion_control;
   import acc_pkg::*;
   typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} acc_row_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, er, strap = 1, special_event, timer_clear, cmp_result;
   logic        fire = 0;
   logic [12:0] pins = 13'h1fff;
   logic [2:0]  rc_div = 3'h0;
   logic [3:0]  mode = 4'hb;
   logic [9:0]  level = 10'h2a5;
   acc_ana_t    ana;
   int          failures = 0, samples_checked = 0, cyc = 0, conv_len, dis_len, cc, dc, tcs;
   acc_row_t    rows [11] = '{
      '{0, 8'h00, 0, 32'h0, 0}, '{0, 8'h04, 0, 32'h0, 0}, '{0, 8'h08, 0, 32'h0, 0},
      '{0, 8'h14, 0, 32'h0, 0}, '{0, 8'h24, 0, 32'h0, 1}, '{1, 8'h24, 32'hff, 0, 1},
      '{1, 8'h18, 32'ha5, 0, 0}, '{0, 8'h18, 0, 32'ha5, 0}, '{1, 8'h04, 32'h0f, 0, 0},
      '{0, 8'h20, 0, 32'h1fff, 0}, '{1, 8'h04, 32'h07, 0, 0}};

   acc_conv_ctrl acc_conv_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pin(pins), .rc_clk(rc_div[2]), .portb_analog_default(strap),
      .compare_mode_field(mode), .special_event(special_event), .timer_clear(timer_clear),
      .cmp_result(cmp_result), .ana(ana));
   acc_far_model acc_far_model_i (.pclk(pclk), .level(level), .fire(fire), .ana(ana),
      .cmp_result(cmp_result), .special_event(special_event));

   // Clock and watchdog; pulse lengths of conversion and discharge
   always #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc = cyc + 1;
      rc_div <= rc_div + 3'h1;
      if (cyc > 20000) begin
         failures = failures + 1;
         conclude();
      end
      if (ana.convert) cc = cc + 1; else if (cc != 0) begin conv_len = cc; cc = 0; end
      if (ana.discharge) dc = dc + 1; else if (dc != 0) begin dis_len = dc; dc = 0; end
      if (timer_clear === 1'b1) tcs = tcs + 1;
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked = samples_checked + 1;
      if (g !== e) begin
         failures = failures + 1;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chk

   // One APB transfer, held until pready is seen at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb

   task reset_dut(input logic s);
      strap <= s; presetn <= 0;
      repeat (5) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
   endtask : reset_dut

   // Poll the done flag a bounded number of times
   task wait_done;
      int n;
      n = 0;
      do begin apb(0, OFF_FLAGS, 0); n = n + 1; end while (rd[FLAGS_DONE] !== 1'b1 && n < 60);
      chk("done", 1, rd[FLAGS_DONE]);
      repeat (12) @(posedge pclk);
   endtask : wait_done

   task conclude;
      if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   initial begin
      cc = 0; dc = 0; tcs = 0;
      reset_dut(1);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) chk("row data", rows[i].e, rd);
         chk("row err", rows[i].r, er);
      end
      apb(0, OFF_PORT, 0);
      chk("port", 32'h1f00, rd);
      pins <= 13'h0a5a;
      repeat (3) @(posedge pclk);
      apb(0, OFF_PORT, 0);
      chk("port mix", 32'h0a00, rd);
      // Timed acquisition of four bit periods, divide by two
      apb(1, OFF_CTRL2, 32'h10);
      apb(1, OFF_CTRL0, 32'h05);
      repeat (8) @(posedge pclk);
      apb(1, OFF_CTRL0, 32'h07);
      wait_done();
      apb(0, OFF_RES_HI, 0);
      chk("res hi", 32'ha9, rd);
      apb(0, OFF_RES_LO, 0);
      chk("res lo", 32'h40, rd);
      apb(0, OFF_CTRL0, 0);
      chk("run clr", 32'h05, rd);
      chk("sampling", 32'h11, {ana.sample_en, ana.channel});
      chk("conv len", 22, conv_len);
      chk("dis len", 4, dis_len);
      // Abort mid-conversion with a new input level
      level <= 10'h0f0;
      apb(1, OFF_FLAGS, 0);
      apb(1, OFF_CTRL0, 32'h07);
      while (ana.convert !== 1'b1 && cyc < 19000) @(posedge pclk);
      repeat (4) @(posedge pclk);
      apb(1, OFF_CTRL0, 32'h05);
      repeat (3) @(posedge pclk);
      chk("aborted", 0, ana.convert);
      repeat (20) @(posedge pclk);
      apb(0, OFF_RES_HI, 0);
      chk("res kept", 32'ha9, rd);
      apb(0, OFF_FLAGS, 0);
      chk("no done", 0, rd);
      chk("dis abort", 4, dis_len);
      // Hardware trigger, manual acquisition
      apb(1, OFF_CTRL2, 32'h00);
      @(posedge pclk) fire <= 1;
      @(posedge pclk) fire <= 0;
      wait_done();
      chk("tmr clr", 1, tcs);
      apb(0, OFF_RES_HI, 0);
      chk("trig res", 32'h3c, rd);
      // Trigger ignored while disabled, timer still cleared
      apb(1, OFF_FLAGS, 0);
      apb(1, OFF_CTRL0, 32'h04);
      @(posedge pclk) fire <= 1;
      @(posedge pclk) fire <= 0;
      repeat (60) @(posedge pclk);
      chk("tmr clr2", 2, tcs);
      apb(0, OFF_CTRL0, 0);
      chk("ignored", 32'h04, rd);
      apb(0, OFF_FLAGS, 0);
      chk("idle", 0, rd);
      // Internal RC bit clock, right justified, digital-configured channel 9
      level <= 10'h35a;
      apb(1, OFF_CTRL2, 32'h93);
      apb(1, OFF_CTRL0, 32'h25);
      repeat (40) @(posedge pclk);
      apb(1, OFF_CTRL0, 32'h27);
      wait_done();
      apb(0, OFF_RES_HI, 0);
      chk("rc res hi", 32'h03, rd);
      apb(0, OFF_RES_LO, 0);
      chk("rc res lo", 32'h5a, rd);
      reset_dut(0);
      apb(0, OFF_CTRL1, 0);
      chk("strap", 32'h07, rd);
      conclude();
   end
endmodule : test_adc_conversion_control
